// File: rtl/cmp_map.svh
`ifndef CMP_MAP_SVH
`define CMP_MAP_SVH
// Byte offsets on the register bus
`define CMP_CTRL0_OFS      8'h00
`define CMP_CTRL1_OFS      8'h04
`define CMP_CTRL2_OFS      8'h08
`define CMP_STATUS_OFS     8'h0C
`define CMP_LADDER_OFS     8'h10
// Comparator control fields
`define CC_ON_BIT          15
`define CC_PIN_BIT         14
`define CC_INV_BIT         13
`define CC_EVT_BIT         9
`define CC_RES_BIT         8
`define CC_EDGE_HI         7
`define CC_EDGE_LO         6
`define CC_PLUS_BIT        4
`define CC_MINUS_HI        1
`define CC_MINUS_LO        0
// Writable bits of the comparator control (result bit is read-only)
`define CC_WMASK           16'hE2D3
// Status fields
`define ST_IDLE_BIT        15
`define ST_EVT_LO          8
`define ST_RES_LO          0
`define ST_WMASK           16'h8000
// Ladder control fields
`define LC_POS_BIT         10
`define LC_NEG_HI          9
`define LC_NEG_LO          8
`define LC_PWR_BIT         7
`define LC_PIN_BIT         6
`define LC_RANGE_BIT       5
`define LC_SUPPLY_BIT      4
`define LC_LEVEL_HI        3
`define LC_WMASK           16'h07FF
// Reset values
`define REG_RESET          16'h0000
`endif

// File: rtl/cmp_pkg.sv
package cmp_pkg;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY  = 2'b11
  } edge_sel_t;

  // Wishbone classic request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wb_rsp_t;

  // Analog-side controls, one per comparator
  typedef struct packed {
    logic       run;
    logic       plus_sel;
    logic [1:0] minus_sel;
  } cmp_ana_t;

  typedef struct packed {
    logic       power_on;
    logic       pin_drive;
    logic       range_sel;
    logic       supply_sel;
    logic [3:0] level;
    logic       pos_src;
    logic [1:0] neg_src;
  } ladder_ana_t;

  typedef struct packed {
    logic [2:0][15:0] ctrl;
    logic             idle_halt;
    logic [15:0]      ladder;
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic [2:0]       prev;
    logic [2:0]       evt;
    logic [2:0]       evt_pulse;
    wb_rsp_t          rsp;
    cmp_ana_t [2:0]   ana;
    ladder_ana_t      lad;
    logic [2:0]       pin_oe;
  } state_t;
endpackage

// File: rtl/triple_comparator_vref_control.sv
`timescale 1ns/1ns
`include "cmp_map.svh"

module triple_comparator_vref_control (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [7:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic                        ack_o,
  output logic                        err_o,
  output logic [31:0]                 dat_o,
  input  wire logic                   idle_mode_i,
  input  wire logic [2:0]             raw_result_i,
  output logic [2:0]                  pin_drive_oe_o,
  output logic [2:0]                  event_pulse_o,
  output cmp_pkg::cmp_ana_t [2:0]     cmp_ana_o,
  output cmp_pkg::ladder_ana_t        ladder_ana_o
);
  import cmp_pkg::*;

  // One state struct holds the bus reply, the three control words, the
  // ladder word, synchroniser stages, flags and registered analog controls.
  // Every output is a field of it, so no pin is driven through logic.
  state_t r_r;
  state_t r_nxt;
  wb_req_t req;
  logic [2:0] result;
  logic [2:0] running;

  // Byte-lane merge limited to implemented, writable bits
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] wm);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wm;
    merge = (old & ~lane) | (wd[15:0] & lane);
  endfunction

  // Edge qualifier for one comparator's selected event
  function automatic logic edge_hit(input logic [1:0] es, input logic inv,
                                    input logic prv, input logic cur);
    logic rise;
    logic fall;
    rise = ~prv & cur;
    fall = prv & ~cur;
    edge_hit = 1'b0;
    unique case (edge_sel_t'(es))
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = inv ? fall : rise;
      EDGE_FALL: edge_hit = inv ? rise : fall;
      EDGE_ANY:  edge_hit = rise | fall;
    endcase
  endfunction

  // Control word as software reads it; the flag and result are live,
  // the stored copy of the flag bit is never shown
  function automatic logic [15:0] ctrl_view(input logic [15:0] stored,
                                            input logic        flag,
                                            input logic        res);
    logic [15:0] v;
    v = stored & `CC_WMASK;
    v[`CC_EVT_BIT] = flag;
    v[`CC_RES_BIT] = res;
    ctrl_view = v;
  endfunction

  // Status word: halt bit plus live mirrors of flags and results;
  // every other position reads zero
  function automatic logic [15:0] status_view(input logic       halt,
                                              input logic [2:0] flags,
                                              input logic [2:0] res);
    logic [15:0] v;
    v = `REG_RESET;
    v[`ST_IDLE_BIT] = halt;
    v[`ST_EVT_LO +: 3] = flags;
    v[`ST_RES_LO +: 3] = res;
    status_view = v;
  endfunction

  // Ladder word: the upper five bits are not built and read zero
  function automatic logic [15:0] ladder_view(input logic [15:0] stored);
    ladder_view = stored & `LC_WMASK;
  endfunction

  // Flag after a control write. The flag lives apart from the stored word,
  // so a write that leaves the upper lane alone keeps the live flag
  function automatic logic flag_after_write(input logic        flag,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic f;
    f = flag;
    if (be[1]) begin
      f = wd[`CC_EVT_BIT];
    end
    flag_after_write = f;
  endfunction

  // Status write: only the idle halt bit takes a value
  function automatic logic halt_after_write(input logic        halt,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [15:0] w;
    w = merge({halt, 15'h0000}, wd, be, `ST_WMASK);
    halt_after_write = w[`ST_IDLE_BIT];
  endfunction

  // Whether a comparator may run; idle halt stops all three at once,
  // enabled comparators keep running in idle when it is clear
  function automatic logic may_run(input logic on, input logic halt, input logic idle);
    may_run = on & ~(halt & idle);
  endfunction

  // Analog-side controls of one comparator, taken from its control word;
  // a stopped comparator also loses its pad enable
  function automatic cmp_ana_t ana_of(input logic [15:0] ctrl,
                                      input logic        halt,
                                      input logic        idle);
    cmp_ana_t a;
    a.run       = may_run(ctrl[`CC_ON_BIT], halt, idle);
    a.plus_sel  = ctrl[`CC_PLUS_BIT];
    a.minus_sel = ctrl[`CC_MINUS_HI:`CC_MINUS_LO];
    ana_of = a;
  endfunction

  // Pad enable; the pad itself carries the unsynchronised analog result,
  // so the pin is not delayed by the synchroniser
  function automatic logic pin_enable(input logic run, input logic [15:0] ctrl);
    pin_enable = run & ctrl[`CC_PIN_BIT];
  endfunction

  // Ladder controls; the analog side does the level arithmetic itself,
  // so the step size and offset are only a range select here
  function automatic ladder_ana_t lad_of(input logic [15:0] lw);
    ladder_ana_t l;
    l.power_on   = lw[`LC_PWR_BIT];
    l.pin_drive  = lw[`LC_PIN_BIT];
    l.range_sel  = lw[`LC_RANGE_BIT];
    l.supply_sel = lw[`LC_SUPPLY_BIT];
    l.level      = lw[`LC_LEVEL_HI:0];
    l.pos_src    = lw[`LC_POS_BIT];
    l.neg_src    = lw[`LC_NEG_HI:`LC_NEG_LO];
    lad_of = l;
  endfunction

  // Event gate: a set flag or a stopped comparator lets no edge through,
  // which keeps one event per flag until software clears it
  function automatic logic event_gate(input logic run,
                                      input logic flag,
                                      input logic hit);
    event_gate = run & ~flag & hit;
  endfunction

  // Reply word: read data in the low half only,
  // zero for writes and for errors
  function automatic logic [31:0] reply_word(input logic        is_rd,
                                             input logic        mapped,
                                             input logic [15:0] rd16);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (is_rd & mapped) begin
      w[15:0] = rd16;
    end
    reply_word = w;
  endfunction

  // A request is taken once; while ack or err shows, a held request
  // is not taken a second time
  function automatic logic bus_taken(input wb_req_t r, input logic busy, input logic want_we);
    bus_taken = r.cyc & r.stb & (r.we == want_we) & ~busy;
  endfunction

  // Register map decode; anything else answers with err
  // and has no effect on any register
  function automatic logic is_mapped(input logic [7:0] a);
    logic m;
    m = 1'b0;
    unique case (a)
      `CMP_CTRL0_OFS:  m = 1'b1;
      `CMP_CTRL1_OFS:  m = 1'b1;
      `CMP_CTRL2_OFS:  m = 1'b1;
      `CMP_STATUS_OFS: m = 1'b1;
      `CMP_LADDER_OFS: m = 1'b1;
      default:         m = 1'b0;
    endcase
    is_mapped = m;
  endfunction

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, sel: sel_i, dat: dat_i};

  // Live result: synchronised analog level, inverted when asked
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      running[i] = may_run(r_r.ctrl[i][`CC_ON_BIT], r_r.idle_halt, idle_mode_i);
      result[i]  = running[i] & (r_r.sync2[i] ^ r_r.ctrl[i][`CC_INV_BIT]);
    end
  end

  always_comb begin
    logic        hit;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    hit = is_mapped(req.adr);
    wr = 1'b0;
    rd = 1'b0;
    rdata = `REG_RESET;
    r_nxt = r_r;
    r_nxt.rsp.ack = 1'b0;
    r_nxt.rsp.err = 1'b0;
    r_nxt.rsp.dat = 32'h0000_0000;

    // Two-stage synchroniser; first stage feeds only the second
    r_nxt.sync1 = raw_result_i;
    r_nxt.sync2 = r_r.sync1;
    r_nxt.prev = result;

    // Events: sticky flag suppresses further edges until cleared
    for (int i = 0; i < 3; i++) begin
      r_nxt.evt_pulse[i] = event_gate(running[i], r_r.evt[i],
        edge_hit(r_r.ctrl[i][`CC_EDGE_HI:`CC_EDGE_LO], r_r.ctrl[i][`CC_INV_BIT],
                 r_r.prev[i], result[i]));
    end

    // Bus access; ack in the cycle after the request is seen
    // Err counts as busy too, so a held unmapped request answers once
    wr = bus_taken(req, r_r.rsp.ack | r_r.rsp.err, 1'b1);
    rd = bus_taken(req, r_r.rsp.ack | r_r.rsp.err, 1'b0);
    unique case (req.adr)
      `CMP_CTRL0_OFS: begin
        // First comparator; a write of 0 to the flag clears it
        hit = 1'b1;
        rdata = ctrl_view(r_r.ctrl[0], r_r.evt[0], result[0]);
        if (wr) begin
          r_nxt.ctrl[0] = merge(r_r.ctrl[0], req.dat, req.sel, `CC_WMASK);
          r_nxt.evt[0]  = flag_after_write(r_r.evt[0], req.dat, req.sel);
        end
      end
      `CMP_CTRL1_OFS: begin
        // Second comparator
        hit = 1'b1;
        rdata = ctrl_view(r_r.ctrl[1], r_r.evt[1], result[1]);
        if (wr) begin
          r_nxt.ctrl[1] = merge(r_r.ctrl[1], req.dat, req.sel, `CC_WMASK);
          r_nxt.evt[1]  = flag_after_write(r_r.evt[1], req.dat, req.sel);
        end
      end
      `CMP_CTRL2_OFS: begin
        // Third comparator
        hit = 1'b1;
        rdata = ctrl_view(r_r.ctrl[2], r_r.evt[2], result[2]);
        if (wr) begin
          r_nxt.ctrl[2] = merge(r_r.ctrl[2], req.dat, req.sel, `CC_WMASK);
          r_nxt.evt[2]  = flag_after_write(r_r.evt[2], req.dat, req.sel);
        end
      end
      `CMP_STATUS_OFS: begin
        hit = 1'b1;
        rdata = status_view(r_r.idle_halt, r_r.evt, result);
        if (wr) begin
          r_nxt.idle_halt = halt_after_write(r_r.idle_halt, req.dat, req.sel);
        end
      end
      `CMP_LADDER_OFS: begin
        hit = 1'b1;
        rdata = ladder_view(r_r.ladder);
        if (wr) r_nxt.ladder = merge(r_r.ladder, req.dat, req.sel, `LC_WMASK);
      end
      default: hit = 1'b0;
    endcase

    // Hardware set wins over a software clear in the same cycle
    for (int i = 0; i < 3; i++) begin
      if (r_nxt.evt_pulse[i]) r_nxt.evt[i] = 1'b1;
    end

    if (wr | rd) begin
      r_nxt.rsp.ack = hit;
      r_nxt.rsp.err = ~hit;                        // Unmapped addresses answer err
      r_nxt.rsp.dat = reply_word(rd, hit, rdata);
    end

    // Analog-side controls, registered from the next-state words so that
    // the pads and the analog cores follow a write at the same edge
    for (int i = 0; i < 3; i++) begin
      r_nxt.ana[i]    = ana_of(r_nxt.ctrl[i], r_nxt.idle_halt, idle_mode_i);
      // Pad drives raw analog result; only the enable is clocked
      r_nxt.pin_oe[i] = pin_enable(r_nxt.ana[i].run, r_nxt.ctrl[i]);
    end

    // Ladder controls follow the ladder word as written
    r_nxt.lad = lad_of(r_nxt.ladder);
  end

  // Single state register; everything clears at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign ack_o          = r_r.rsp.ack;
  assign err_o          = r_r.rsp.err;
  assign dat_o          = r_r.rsp.dat;
  assign pin_drive_oe_o = r_r.pin_oe;
  assign event_pulse_o  = r_r.evt_pulse;
  assign cmp_ana_o      = r_r.ana;
  assign ladder_ana_o   = r_r.lad;
endmodule

// File: tb/analog_cores.sv
`timescale 1ns/1ns
module analog_cores import cmp_pkg::*; (
  input wire logic       clk_i,
  input cmp_ana_t [2:0]  ana_i,
  input wire logic [2:0] lvl_i,
  output logic [2:0]     raw_o
);
  logic [2:0] junk_r = 3'b101;
  // Stopped cores show a changing pattern, never a held value
  always_ff @(posedge clk_i) begin
    junk_r <= ~junk_r;
  end
  // High when plus input above minus, only while running
  always_comb begin
    for (int i = 0; i < 3; i++) raw_o[i] = ana_i[i].run ? lvl_i[i] : junk_r[i];
  end
endmodule

// File: tb/cmp_asserts.sv
`timescale 1ns/1ns
module cmp_asserts import cmp_pkg::*; (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic        idle_mode_i,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic [31:0] dat_o,
  input wire logic [2:0]  pin_drive_oe_o,
  input wire logic [2:0]  event_pulse_o,
  input ladder_ana_t      ladder_ana_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_answer; cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o; endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_rd_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");
  property p_excl; !(ack_o && err_o); endproperty
  a_excl: assert property (p_excl) else $error("ack with err");
  property p_sticky; event_pulse_o[0] |=> !event_pulse_o[0]; endproperty
  a_sticky: assert property (p_sticky) else $error("event while flag set");
  property p_rst; $fell(rst_i) |-> !ack_o && event_pulse_o == 3'b000 && pin_drive_oe_o == 3'b000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_lad; !(cyc_i && stb_i && we_i) |=> $stable(ladder_ana_o); endproperty
  a_lad: assert property (p_lad) else $error("ladder moved");
  property p_oe; (!(cyc_i && stb_i && we_i) && $stable(idle_mode_i)) [*2] |-> $stable(pin_drive_oe_o);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable moved");
endmodule
bind triple_comparator_vref_control cmp_asserts chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .idle_mode_i, .ack_o, .err_o, .dat_o, .pin_drive_oe_o, .event_pulse_o, .ladder_ana_o);

// File: tb/triple_comparator_vref_control_bench.sv
`timescale 1ns/1ns
`include "cmp_map.svh"
module triple_comparator_vref_control_bench;
  import cmp_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, idle = 0, ack, err, e_seen;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, q, dout;
  logic [2:0] lvl = 0, raw, oe, evp;
  cmp_ana_t [2:0] ana;
  ladder_ana_t lad;
  int errors = 0, num_checks = 0;
  always #25 clk_i = ~clk_i;
  triple_comparator_vref_control uut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .ack_o(ack), .err_o(err), .dat_o(dout),
    .idle_mode_i(idle), .raw_result_i(raw), .pin_drive_oe_o(oe), .event_pulse_o(evp),
    .cmp_ana_o(ana), .ladder_ana_o(lad));
  analog_cores far (.clk_i, .ana_i(ana), .lvl_i(lvl), .raw_o(raw));
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Holds the request until the answer edge, then releases
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = dout;
    e_seen = err;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic edge_to(input logic v, input int e, input string n);
    int c = 0;
    @(posedge clk_i);
    lvl[0] <= v;
    repeat (10) begin
      @(negedge clk_i);
      c += evp[0];
    end
    chk(n, e, c);
  endtask
  task automatic t_reset;
    for (int a = 0; a < 5; a++) begin
      wb(0, 8'(a * 4), 0);
      chk("reset value", 0, q);
    end
    wb(0, 8'h14, 0);
    chk("unmapped err", 1, e_seen);
  endtask
  task automatic t_ctrl;
    wb(1, `CMP_CTRL0_OFS, 32'hFFFF_FFFF);
    repeat (6) @(posedge clk_i);
    wb(0, `CMP_CTRL0_OFS, 0);
    chk("ctrl read", 32'h0000_E3D3, q);
    chk("ana", 4'hF, ana[0]);
    chk("pin oe", 3'b001, oe);
    wb(0, `CMP_STATUS_OFS, 0);
    chk("status", 32'h0000_0101, q);
    for (int m = 0; m < 4; m++) begin
      wb(1, `CMP_CTRL0_OFS, 32'h0000_8000 | m);
      repeat (2) @(posedge clk_i);
      chk("minus sel", 4'b1000 | m, ana[0]);
    end
    wb(1, `CMP_STATUS_OFS, 32'h0000_8000);
    idle <= 1;
    repeat (3) @(posedge clk_i);
    chk("idle run", 0, ana[0].run);
    idle <= 0;
    repeat (3) @(posedge clk_i);
    chk("wake run", 1, ana[0].run);
  endtask
  task automatic t_events;
    logic [31:0] cfg;
    for (int k = 0; k < 8; k++) begin
      cfg = 32'h0000_8000 | (k[2] << 13) | (k[1:0] << 6);
      wb(1, `CMP_CTRL0_OFS, cfg);
      repeat (8) @(posedge clk_i);
      wb(1, `CMP_CTRL0_OFS, cfg);
      edge_to(1, k[0], "rise events");
      wb(1, `CMP_CTRL0_OFS, cfg);
      edge_to(0, k[1], "fall events");
    end
    edge_to(1, 0, "sticky block");
  endtask
  task automatic t_ladder;
    wb(1, `CMP_LADDER_OFS, 32'hFFFF_FFFF);
    wb(0, `CMP_LADDER_OFS, 0);
    chk("ladder mask", 32'h0000_07FF, q);
    wb(1, `CMP_LADDER_OFS, 32'h0000_05A5);
    repeat (2) @(posedge clk_i);
    chk("ladder ana", 11'h52D, lad);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Whole run is under a thousand cycles
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_ctrl();
    t_events();
    t_ladder();
    results();
  end
endmodule
